// *** design/prs_top.sv ***
`include "prs_defines.svh"

module prs_top #(
    parameter int unsigned PPG_CYC = `PRS_T_PPG_MS * `PRS_MCLK_KHZ,
    parameter int unsigned EE_CYC  = `PRS_T_EE_MS * `PRS_MCLK_KHZ,
    parameter int unsigned TRN_CYC = `PRS_T_TRN_MS * `PRS_MCLK_KHZ,
    parameter int unsigned RES_CYC = `PRS_T_RES_MS * `PRS_MCLK_KHZ
) (
    // clocks and reset
    input  wire logic                   mclk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   lclk_i,
    // host and platform pins
    input  wire logic                   host_fundamental_reset_n_i,
    input  wire logic                   pwr_valid_i,
    input  wire logic                   device_off_n_i,
    input  wire logic                   port0_disable_n_i,
    input  wire logic                   port1_disable_n_i,
    // pll
    input  wire logic                   pll_lock_i,
    output logic                        pll_rst_o,
    output logic                        pll_fail_o,
    // eeprom reload
    output logic                        ee_load_start_o,
    input  wire logic                   ee_done_i,
    input  wire prs_pkg::prs_ee_cfg_t   ee_cfg_i,
    output logic                        ee_timeout_o,
    // control inputs from chip logic
    input  wire logic [`PRS_NPORT-1:0]  extended_control_register_lp_i,
    input  wire logic                   copper_only_i,
    input  wire logic                   mgmt_en_i,
    input  wire logic                   fw_pd_i,
    input  wire logic [`PRS_NPORT-1:0]  func_d0_i,
    input  wire logic [`PRS_NPORT-1:0]  pme_en_i,
    // link side, on lclk_i
    input  wire logic                   cfg_wr_i,
    input  wire prs_pkg::prs_cfg_wr_t   cfg_data_i,
    output logic                        cfg_ready_o,
    output logic                        link_train_o,
    output logic                        elec_idle_o,
    // status
    output logic                        int_pg_o,
    output logic                        int_frst_o,
    output logic                        phy_rst_o,
    output prs_pkg::prs_phy_mode_t      phy_mode_o,
    output prs_pkg::prs_pstate_t        power_state_o,
    output logic                        advanced_wake_mode_o,
    output logic [`PRS_NPORT-1:0]       serial_link_interface_pd_o,
    output logic                        global_pd_o
);
    import prs_pkg::*;

    localparam int unsigned PLL_CYC =
        `PRS_T_PLL_US * `PRS_MCLK_KHZ / `PRS_KHZ_PER_MHZ;

    // decoded state helpers
    function automatic logic prs_is_reset(input prs_pstate_t s);
        return s == PS_RESET;
    endfunction

    function automatic logic prs_is_uninit(input prs_pstate_t s);
        return (s == PS_D0U) || (s == PS_D3);
    endfunction

    logic [5:0]            pin_s;
    logic                  host_rst_n_s;
    logic                  pwr_ok_s;
    logic                  device_off_n_s;
    logic                  pll_lock_s;
    logic [`PRS_NPORT-1:0] dis_n_s;
    logic                  pg_done;
    logic                  pg_reg;
    logic                  int_frst_reg;
    logic                  frst_d_reg;
    logic                  frst_rise;
    logic                  loading_reg;
    logic                  loaded_reg;
    logic                  ee_to;
    logic                  load_end;
    prs_ee_cfg_t           ee_cfg_reg;
    logic                  apm_reg;
    logic                  phy_rst_reg;
    logic                  pll_to;
    logic                  pll_fail_reg;
    logic                  ee_timeout_reg;
    logic                  trn_done;
    logic                  res_done;
    logic                  train_req_reg;
    logic                  cfg_ready_reg;
    prs_pstate_t           state_reg;
    prs_pstate_t           state_next;
    prs_phy_mode_t         phy_mode_reg;
    logic [`PRS_NPORT-1:0] serial_link_interface_pd_reg;
    logic [`PRS_NPORT-1:0] link_pd;
    logic                  global_pd_reg;
    logic                  lrst_n;
    logic                  cfg_tgl_reg;
    prs_cfg_wr_t           cfg_hold_reg;
    logic                  cfg_tgl_s;
    logic                  cfg_last_reg;
    logic                  cfg_ev;
    logic [1:0]            link_s;
    logic                  lrst_sync_n;

    // pins into the main clock domain
    prs_sync2 #(.W(6), .RV(`PRS_PIN_RV)) u_pin_sync (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .d_i     ({pll_lock_i, port1_disable_n_i, port0_disable_n_i,
                   device_off_n_i, pwr_valid_i, host_fundamental_reset_n_i}),
        .q_o     (pin_s)
    );

    assign host_rst_n_s = pin_s[`PRS_PIN_HRST];
    assign pwr_ok_s     = pin_s[`PRS_PIN_PWR];
    assign device_off_n_s  = pin_s[`PRS_PIN_DOFF];
    assign pll_lock_s   = pin_s[`PRS_PIN_LOCK];
    assign dis_n_s      = {pin_s[`PRS_PIN_DIS1], pin_s[`PRS_PIN_DIS0]};

    // power good counter, flop adds the last cycle
    prs_delay #(.CYC(PPG_CYC - 1)) u_pg_dly (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .run_i   (pwr_ok_s),
        .done_o  (pg_done)
    );

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pg_reg <= 1'b0;
        end else begin
            pg_reg <= pg_done;
        end
    end

    // internal fundamental reset, one cycle behind the synchroniser
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_frst_reg <= 1'b1;
            frst_d_reg   <= 1'b0;
        end else begin
            int_frst_reg <= !(host_rst_n_s && pg_reg);
            frst_d_reg   <= int_frst_reg;
        end
    end

    assign frst_rise = int_frst_reg && !frst_d_reg;
    assign load_end  = loading_reg && (ee_done_i || ee_to);

    // eeprom reload bounded by a timeout; a new reset rise restarts the count
    prs_delay #(.CYC(EE_CYC - 1)) u_ee_dly (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .run_i   (loading_reg && !frst_rise),
        .done_o  (ee_to)
    );

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loading_reg     <= 1'b0;
            loaded_reg      <= 1'b0;
            ee_load_start_o <= 1'b0;
        end else begin
            ee_load_start_o <= frst_rise;
            if (frst_rise) begin
                loading_reg <= 1'b1;
                loaded_reg  <= 1'b0;
            end else if (load_end) begin
                loading_reg <= 1'b0;
                loaded_reg  <= 1'b1;
            end
        end
    end

    // loaded bits and wake enable; timeout leaves defaults
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ee_cfg_reg     <= '0;
            apm_reg        <= 1'b0;
            ee_timeout_reg <= 1'b0;
        end else if (frst_rise) begin
            apm_reg        <= 1'b0;
            ee_timeout_reg <= 1'b0;
        end else if (loading_reg && ee_done_i) begin
            ee_cfg_reg <= ee_cfg_i;
            apm_reg    <= ee_cfg_i.apm_en;
        end else if (ee_to) begin
            ee_cfg_reg     <= '0;
            ee_timeout_reg <= 1'b1;
        end
    end

    // phy held in reset from reset assertion to load end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_rst_reg <= 1'b1;
        end else begin
            phy_rst_reg <= frst_rise || (phy_rst_reg && !load_end);
        end
    end

    // pll watchdog after reset release
    prs_delay #(.CYC(PLL_CYC)) u_pll_dly (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .run_i   (!int_frst_reg && !pll_lock_s),
        .done_o  (pll_to)
    );

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pll_rst_o    <= 1'b1;
            pll_fail_reg <= 1'b0;
        end else begin
            pll_rst_o <= int_frst_reg;
            if (pll_to) begin
                pll_fail_reg <= 1'b1;
            end else if (int_frst_reg) begin
                pll_fail_reg <= 1'b0;
            end
        end
    end

    // training and completion deadlines from reset release
    prs_delay #(.CYC(TRN_CYC - `PRS_XING_CYC)) u_trn_dly (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .run_i   (!int_frst_reg),
        .done_o  (trn_done)
    );

    prs_delay #(.CYC(RES_CYC - `PRS_XING_CYC)) u_res_dly (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .run_i   (!int_frst_reg),
        .done_o  (res_done)
    );

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            train_req_reg <= 1'b0;
            cfg_ready_reg <= 1'b0;
        end else if (int_frst_reg) begin
            train_req_reg <= 1'b0;
            cfg_ready_reg <= 1'b0;
        end else begin
            if ((loaded_reg && pll_lock_s) || trn_done) begin
                train_req_reg <= 1'b1;
            end
            if ((train_req_reg && loaded_reg) || res_done) begin
                cfg_ready_reg <= 1'b1;
            end
        end
    end

    // link domain held idle while the internal reset stands
    assign lrst_n = arst_n_i && !int_frst_reg;

    // reset enters the link domain at once, leaves it on lclk
    prs_sync2 #(.W(1), .RV(1'b0)) u_lrst_sync (
        .clk_i   (lclk_i),
        .rst_n_i (lrst_n),
        .d_i     (1'b1),
        .q_o     (lrst_sync_n)
    );

    // config write capture and toggle on the link clock
    always_ff @(posedge lclk_i or negedge lrst_sync_n) begin
        if (!lrst_sync_n) begin
            cfg_tgl_reg  <= 1'b0;
            cfg_hold_reg <= '0;
        end else if (cfg_wr_i) begin
            cfg_tgl_reg  <= !cfg_tgl_reg;
            cfg_hold_reg <= cfg_data_i;
        end
    end

    prs_sync2 #(.W(2), .RV(2'h0)) u_link_sync (
        .clk_i   (lclk_i),
        .rst_n_i (lrst_sync_n),
        .d_i     ({cfg_ready_reg, train_req_reg}),
        .q_o     (link_s)
    );

    assign link_train_o = link_s[0];
    assign cfg_ready_o  = link_s[1];
    assign elec_idle_o  = !link_s[0];

    prs_sync2 #(.W(1), .RV(1'b0)) u_cfg_sync (
        .clk_i   (mclk_i),
        .rst_n_i (arst_n_i),
        .d_i     (cfg_tgl_reg),
        .q_o     (cfg_tgl_s)
    );

    // toggle edge marks one config write; held data is stable
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_last_reg <= 1'b0;
        end else begin
            cfg_last_reg <= cfg_tgl_s;
        end
    end

    assign cfg_ev = cfg_tgl_s ^ cfg_last_reg;

    // power state next value
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PS_RESET: begin
                if (!int_frst_reg && loaded_reg) begin
                    state_next = PS_D0U;
                end
            end
            PS_D0U: begin
                if (cfg_ev && (cfg_hold_reg.mem_en || cfg_hold_reg.io_en)) begin
                    state_next = PS_D0A;
                end else if (cfg_ev && cfg_hold_reg.d3) begin
                    state_next = PS_D3;
                end
            end
            PS_D0A: begin
                if (cfg_ev && cfg_hold_reg.d3) begin
                    state_next = PS_D3;
                end
            end
            PS_D3: begin
                if (cfg_ev && cfg_hold_reg.d0) begin
                    state_next = PS_D0U;
                end
            end
            default: begin
                state_next = PS_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= PS_RESET;
        end else if (int_frst_reg) begin
            state_reg <= PS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // phy mode: full in d0a, reduced in d0u and d3 when the wake mode or management is enabled
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_mode_reg <= PHY_OFF;
        end else if (phy_rst_reg || prs_is_reset(state_reg)) begin
            phy_mode_reg <= PHY_OFF;
        end else if (prs_is_uninit(state_reg)) begin
            phy_mode_reg <= (apm_reg || mgmt_en_i) ? PHY_LOW : PHY_OFF;
        end else begin
            phy_mode_reg <= PHY_FULL;
        end
    end

    // per-port serial link power-down
    genvar gi;
    generate
        for (gi = 0; gi < `PRS_NPORT; gi++) begin : g_port
            logic lp_en;
            assign lp_en = ee_cfg_reg.serial_link_interface_lp[gi] || extended_control_register_lp_i[gi];
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    serial_link_interface_pd_reg[gi] <= 1'b0;
                end else begin
                    serial_link_interface_pd_reg[gi] <=
                        (lp_en && !func_d0_i[gi] && !apm_reg && !(|pme_en_i))
                        || copper_only_i
                        || (!dis_n_s[gi] && ee_cfg_reg.serial_link_interface_lp[gi]);
                end
            end
            assign link_pd[gi] = serial_link_interface_pd_reg[gi] && (phy_mode_reg == PHY_OFF);
        end
    endgenerate

    // global power-down
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            global_pd_reg <= 1'b0;
        end else begin
            global_pd_reg <= (ee_cfg_reg.pd_en && prs_is_reset(state_reg) && (&link_pd))
                || (ee_cfg_reg.pd_en && !device_off_n_s)
                || fw_pd_i;
        end
    end

    // outputs
    assign int_pg_o                   = pg_reg;
    assign int_frst_o                 = int_frst_reg;
    assign phy_rst_o                  = phy_rst_reg;
    assign phy_mode_o                 = phy_mode_reg;
    assign power_state_o              = state_reg;
    assign advanced_wake_mode_o       = apm_reg;
    assign serial_link_interface_pd_o = serial_link_interface_pd_reg;
    assign global_pd_o                = global_pd_reg;
    assign pll_fail_o                 = pll_fail_reg;
    assign ee_timeout_o               = ee_timeout_reg;

    // checks on the main clock domain
    default clocking cb_main @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_reset_state: assert property (int_frst_reg |=> state_reg == PS_RESET)
        else $error("reset state not entered");
    a_int_rst_fast: assert property (!host_rst_n_s |=> int_frst_reg)
        else $error("internal reset late");
    a_reload_start: assert property (frst_rise |=> ee_load_start_o && phy_rst_o
        && !advanced_wake_mode_o)
        else $error("reset did not start reload");
    a_apm_loaded: assert property (loading_reg && ee_done_i && !frst_rise
        |=> advanced_wake_mode_o == $past(ee_cfg_i.apm_en))
        else $error("wake mode not loaded");
    a_phy_held: assert property (loading_reg |-> phy_rst_o)
        else $error("phy released during load");
    a_train_due: assert property (trn_done && !int_frst_reg |=> train_req_reg)
        else $error("training not started");
    a_pll_flag: assert property (pll_to && !int_frst_reg |=> pll_fail_o)
        else $error("pll timeout not flagged");
    a_cfg_ready: assert property (res_done && !int_frst_reg |=> cfg_ready_reg)
        else $error("completion not enabled");
    a_d0a_entry: assert property (state_reg == PS_D0U && cfg_ev && cfg_hold_reg.mem_en
        && !int_frst_reg |=> state_reg == PS_D0A)
        else $error("d0a not entered");
    a_pg_drop: assert property (!pwr_ok_s |=> ##1 !pg_reg)
        else $error("power good without power");
    a_serial_link_interface_pd: assert property (!func_d0_i[0] && extended_control_register_lp_i[0]
        && !apm_reg && pme_en_i == '0 |=> serial_link_interface_pd_o[0])
        else $error("serial link not down");
    a_copper_pd: assert property (copper_only_i |=> &serial_link_interface_pd_o)
        else $error("copper-only link not down");
    a_gpd_cause: assert property ($rose(global_pd_o) |-> $past(fw_pd_i)
        || $past(ee_cfg_reg.pd_en))
        else $error("global power-down without enable");
    a_fw_pd: assert property (fw_pd_i |=> global_pd_o)
        else $error("firmware power-down ignored");
    a_phy_full: assert property (state_reg == PS_D0A && !phy_rst_reg
        |=> phy_mode_o == PHY_FULL)
        else $error("phy not full in d0a");
endmodule

// *** design/prs_defines.svh ***
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

// clock rate and unit scale
`define PRS_MCLK_KHZ     40000
`define PRS_KHZ_PER_MHZ  1000

// guaranteed and required times, as printed
`define PRS_T_PPG_MS     35
`define PRS_T_EE_MS      20
`define PRS_T_TRN_MS     20
`define PRS_T_PLL_US     50
`define PRS_T_RES_MS     1000

// margin for synchroniser latency into the link domain
`define PRS_XING_CYC     16

// port count and pin synchroniser reset value
`define PRS_NPORT        2
`define PRS_PIN_RV       6'h1c

// pin synchroniser bit positions
`define PRS_PIN_HRST     0
`define PRS_PIN_PWR      1
`define PRS_PIN_DOFF     2
`define PRS_PIN_DIS0     3
`define PRS_PIN_DIS1     4
`define PRS_PIN_LOCK     5

`endif

// *** design/prs_pkg.sv ***
package prs_pkg;

    // device power state, gray along reset -> d0u -> d0a -> d3
    typedef enum logic [1:0] {
        PS_RESET = 2'h0,
        PS_D0U   = 2'h1,
        PS_D0A   = 2'h3,
        PS_D3    = 2'h2
    } prs_pstate_t;

    // phy power / speed mode
    typedef enum logic [1:0] {
        PHY_OFF  = 2'h0,
        PHY_LOW  = 2'h1,
        PHY_FULL = 2'h3
    } prs_phy_mode_t;

    // configuration bits delivered by the eeprom reload
    typedef struct packed {
        logic       apm_en;
        logic       pd_en;
        logic [1:0] serial_link_interface_lp;
    } prs_ee_cfg_t;

    // configuration write seen on the link side
    typedef struct packed {
        logic mem_en;
        logic io_en;
        logic d3;
        logic d0;
    } prs_cfg_wr_t;

endpackage

// *** design/prs_sync2.sv ***
module prs_sync2 #(
    parameter int         W  = 1,
    parameter logic [W-1:0] RV = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RV;
            q_o      <= RV;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// *** design/prs_delay.sv ***
module prs_delay #(
    parameter int unsigned CYC = 1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic run_i,
    output logic      done_o
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt_reg;

    // counts while run is high, clears when it drops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (!run_i) begin
            cnt_reg <= '0;
        end else if (cnt_reg != W'(CYC)) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign done_o = run_i && (cnt_reg == W'(CYC));
endmodule

// *** test/prs_host_model.sv ***
module prs_host_model (
    // reference clock
    output logic                 lclk_o,
    // configuration writes
    input  wire logic            cfg_ready_i,
    output logic                 cfg_wr_o,
    output prs_pkg::prs_cfg_wr_t cfg_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;

    // free-running refclk, never stopped by this host
    initial begin
        lclk_o = 1'b0;
        #7;
        forever #62.5 lclk_o = ~lclk_o;
    end

    // idle write strobe
    initial begin
        cfg_wr_o   = 1'b0;
        cfg_data_o = '0;
    end

    // one write, held off until the device can answer
    task automatic cfg_write(input prs_cfg_wr_t d);
        int k;
        @(posedge lclk_o);
        for (k = 0; k < 400 && cfg_ready_i !== 1'b1; k++) @(posedge lclk_o);
        cfg_wr_o   <= 1'b1;
        cfg_data_o <= d;
        @(posedge lclk_o);
        cfg_wr_o   <= 1'b0;
        cfg_data_o <= ~d; // stale data never left on the lines
        @(posedge lclk_o);
    endtask
endmodule

// *** test/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;

    logic mclk, arst_n, hrst_n, pwr, doff_n, lock, ee_start, ee_done, ee_to, copper, mgmt;
    logic fw_pd, cfg_wr, cfg_rdy, train, eidle, pg, frst, phy_rst, pll_fail, awm, gpd;
    logic [1:0] dis_n, ext_lp, func_d0, pme, slpd;
    logic        lclk;
    logic        pll_rst, ee_mute;
    prs_ee_cfg_t   ee_cfg;
    prs_cfg_wr_t   cfg_d;
    prs_phy_mode_t phy_mode;
    prs_pstate_t   pstate;
    int          miscompares, n_tests, cyc, ee_cnt, k, i, p;
    logic [31:0] r;
    logic        e;

    prs_top #(.PPG_CYC(200), .EE_CYC(300), .TRN_CYC(400), .RES_CYC(600)) i_dut (
        .mclk_i(mclk), .arst_n_i(arst_n), .lclk_i(lclk), .host_fundamental_reset_n_i(hrst_n),
        .pwr_valid_i(pwr), .device_off_n_i(doff_n), .port0_disable_n_i(dis_n[0]),
        .port1_disable_n_i(dis_n[1]), .pll_lock_i(lock), .pll_rst_o(pll_rst),
        .pll_fail_o(pll_fail),
        .ee_load_start_o(ee_start), .ee_done_i(ee_done), .ee_cfg_i(ee_cfg), .ee_timeout_o(ee_to),
        .extended_control_register_lp_i(ext_lp), .copper_only_i(copper), .mgmt_en_i(mgmt),
        .fw_pd_i(fw_pd), .func_d0_i(func_d0), .pme_en_i(pme), .cfg_wr_i(cfg_wr),
        .cfg_data_i(cfg_d), .cfg_ready_o(cfg_rdy), .link_train_o(train), .elec_idle_o(eidle),
        .int_pg_o(pg), .int_frst_o(frst), .phy_rst_o(phy_rst), .phy_mode_o(phy_mode),
        .power_state_o(pstate), .advanced_wake_mode_o(awm), .serial_link_interface_pd_o(slpd),
        .global_pd_o(gpd));

    prs_host_model i_host (.lclk_o(lclk), .cfg_ready_i(cfg_rdy), .cfg_wr_o(cfg_wr),
        .cfg_data_o(cfg_d));

    // main clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // eeprom answers 20 cycles after each reload start, unless muted
    always @(posedge mclk) begin
        if (ee_start === 1'b1) ee_cnt <= 20;
        else if (ee_cnt != 0) ee_cnt <= ee_cnt - 1;
        ee_done <= (ee_cnt == 1) && !ee_mute;
    end

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // release host reset once power good stands, then follow bring-up
    task automatic boot(input prs_ee_cfg_t c);
        ee_cfg <= c;
        for (k = 0; k < 400 && pg !== 1'b1; k++) @(posedge mclk);
        chk("pg", pg, 1'b1);
        hrst_n <= 1'b1;
        for (k = 0; k < 400 && frst !== 1'b0; k++) @(posedge mclk);
        for (k = 0; k < 400 && phy_rst !== 1'b0; k++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk("awm", awm, c.apm_en);
        chk("ee_to", ee_to, 1'b0);
        chk("pstate", pstate, PS_D0U);
        chk("pll_rst", pll_rst, 1'b0);
        chk("phy_mode", phy_mode, c.apm_en ? PHY_LOW : PHY_OFF);
        for (k = 0; k < 800 && train !== 1'b1; k++) @(posedge mclk);
        chk("eidle", eidle, 1'b0);
        chk("pll_fail", pll_fail, 1'b0);
        $display("test boot done");
    endtask

    initial begin
        {arst_n, hrst_n, pwr, lock, copper, mgmt, fw_pd, ee_done, ee_mute} = '0;
        {doff_n, dis_n, func_d0} = '1;
        {ext_lp, pme, ee_cnt, cyc, miscompares, n_tests} = '0;
        ee_cfg = '0;
        r = 32'h6f4883f0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        pwr    <= 1'b1;
        lock   <= 1'b1;
        boot(4'h9); // wake scheme and port 0 link low-power, pme stays off
        i_host.cfg_write(4'h8);
        repeat (8) @(posedge mclk);
        chk("pstate", pstate, PS_D0A);
        chk("phy_mode", phy_mode, PHY_FULL);
        @(posedge mclk);
        hrst_n <= 1'b0;
        for (k = 0; k < 10 && frst !== 1'b1; k++) @(posedge mclk);
        chk("frst", frst, 1'b1);
        for (k = 0; k < 4 && ee_start !== 1'b1; k++) @(posedge mclk);
        chk("ee_start", ee_start, 1'b1);
        repeat (4) @(posedge mclk);
        chk("pstate", pstate, PS_RESET);
        chk("eidle", eidle, 1'b1);
        chk("phy_rst", phy_rst, 1'b1);
        chk("awm", awm, 1'b0);
        chk("pll_rst", pll_rst, 1'b1);
        $display("test host reset done");
        r = lfsr(r);
        boot({2'h1, r[1:0]}); // power-down enable set for the global checks
        for (i = 0; i < 16; i++) begin
            r = lfsr(r);
            dis_n   <= r[3:2];
            ext_lp  <= r[1:0] & r[3:2];
            func_d0 <= r[5:4];
            pme     <= r[7:6];
            copper  <= r[8] & r[9];
            mgmt    <= r[10];
            fw_pd   <= r[11];
            doff_n  <= r[12];
            repeat (8) @(posedge mclk);
            for (p = 0; p < 2; p++) begin
                e = ((ee_cfg.serial_link_interface_lp[p] | ext_lp[p]) & !func_d0[p] & !ee_cfg.apm_en
                    & pme == 2'h0) | copper | (!dis_n[p] & ee_cfg.serial_link_interface_lp[p]);
                chk("slpd", slpd[p], e);
            end
            chk("gpd", gpd, fw_pd | (ee_cfg.pd_en & !doff_n));
            chk("phy_mode", phy_mode, mgmt ? PHY_LOW : PHY_OFF);
        end
        $display("test link power-down done");
        // reload never answers and the pll stays unlocked: deadlines take over
        ee_mute <= 1'b1;
        lock    <= 1'b0;
        copper  <= 1'b1;
        fw_pd   <= 1'b0;
        doff_n  <= 1'b1;
        hrst_n  <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("gpd", gpd, ee_cfg.pd_en);
        hrst_n <= 1'b1;
        for (k = 0; k < 400 && train !== 1'b1; k++) @(posedge mclk);
        chk("train", train, 1'b1);
        chk("ee_to", ee_to, 1'b1);
        chk("phy_rst", phy_rst, 1'b0);
        chk("awm", awm, 1'b0);
        for (k = 0; k < 2100 && pll_fail !== 1'b1; k++) @(posedge mclk);
        chk("pll_fail", pll_fail, 1'b1);
        chk("cfg_rdy", cfg_rdy, 1'b1);
        $display("test deadlines done");
        summarize();
    end
endmodule
